// File: verilog/bridge_driver_status_special_regs.sv
// Functional notes
// - clearing the transfer bit moves latched first-register faults to second, code becomes 1111
// - transfer ignored while power-stage supply is under-voltage
// - transfer bit reads 1; writing 1 does nothing
// - writing 0 to bit 4 clears stored errors of second register
// - supply monitor bit 0 reads 0 on over-voltage, else 1
// - power-stage under-voltage never clears the over-voltage flag
// - over-voltage flag cleared only by latch bit, serial reset or supply reset
// - only configuration and clear bits of supply monitor are writable
// - special bit 2 selects fast (1) or slow (0) edges
// - special bit 0 enables jittered state machine clock
// - supply power-up loads power-up default of every register
// - each enable or disable edge applies enable/disable reset values
// - while disabled by pin levels, only config stage-control bits stay forced; disable-reset values land on the edge
// - config reset bit acts as serial reset to serial defaults
// - reading a register returns its clear-on-read bits to inactive
// - transfer bit resets first diagnosis register fault bits
// - reading first register keeps bits; only transfer, enable/disable edges, serial reset or supply reset clear them
`timescale 1ns/1ps

module bridge_driver_status_special_regs
    import bridge_regs_pkg::*;
(
    // clock and reset
    input wire logic core_clk,
    input wire logic reset_n,
    // serial port pins
    input wire logic chip_select_n_pin,
    input wire logic sck_pin,
    input wire logic si_pin,
    output logic so_out,
    output logic so_oe,
    // power stage enable pins
    input wire logic disable_pin,
    input wire logic ability_pin_in,
    output logic ability_pin_out,
    output logic ability_pin_oe,
    // analog monitors and fault detection
    input wire bridge_regs_pkg::monitor_t monitor_in,
    input wire logic fault_valid,
    input wire logic [3:0] fault_code,
    // options to the power stage and clock
    output bridge_regs_pkg::option_out_t options
);

    // ------------------------------------------------------------
    // declarations
    // ------------------------------------------------------------
    logic [4:0] pin_meta;
    logic [4:0] pin_sync;
    monitor_t mon_meta;
    monitor_t mon;
    logic sck_prev, cs_n_prev, disabled_prev;
    logic cs_n, sck, si, ability;
    logic sck_rise, sck_fall, cs_fall, cs_rise;
    logic stage_disabled, enable_edge_reset;
    logic [4:0] bit_cnt_reg;
    logic [15:0] rx_shift_reg;
    logic [7:0] instr_reg;
    logic instr_ok_reg;
    logic [7:0] tx_shift_reg;
    logic trans_fail_reg;
    logic [7:0] instr_now;
    logic cmd_ok;
    logic [7:0] answer;
    logic decode_strobe, read_dia2, commit;
    logic [7:0] wdata;
    logic transfer, diag2_clear, serial_command_reset;
    logic ot1_reg, ot2_reg, cur_red_reg, cur_lim_reg;
    logic [3:0] diag1_code_reg, diag2_code_reg;
    logic [2:0] statcon_cfg_reg;
    logic ov_flag_reg;
    logic [7:0] special_reg;
    logic [7:0] dia1_view, dia2_view, statcon_view, config_view;

    // ------------------------------------------------------------
    // input synchronisers
    // ------------------------------------------------------------
    // pins and analog monitors are asynchronous to core_clk
    always_ff @(posedge core_clk)
    begin
        if (!reset_n)
        begin
            pin_meta <= PIN_IDLE;
            pin_sync <= PIN_IDLE;
            mon_meta <= MONITOR_IDLE;
            mon <= MONITOR_IDLE;
        end
        else
        begin
            pin_meta <= {chip_select_n_pin, sck_pin, si_pin, disable_pin, ability_pin_in};
            pin_sync <= pin_meta;
            mon_meta <= monitor_in;
            mon <= mon_meta;
        end
    end

    assign cs_n = pin_sync[4];
    assign sck = pin_sync[3];
    assign si = pin_sync[2];
    assign ability = pin_sync[0];

    // edge history, read from the second stage only
    always_ff @(posedge core_clk)
    begin
        if (!reset_n)
        begin
            sck_prev <= 1'b0;
            cs_n_prev <= 1'b1;
            disabled_prev <= 1'b0;
        end
        else
        begin
            sck_prev <= sck;
            cs_n_prev <= cs_n;
            disabled_prev <= stage_disabled;
        end
    end

    assign sck_rise = sck & ~sck_prev & ~cs_n;
    assign sck_fall = ~sck & sck_prev & ~cs_n;
    assign cs_fall = ~cs_n & cs_n_prev;
    assign cs_rise = cs_n & ~cs_n_prev;
    // stages off when disable high or ability low
    assign stage_disabled = pin_sync[1] | ~ability;
    assign enable_edge_reset = stage_disabled ^ disabled_prev;

    // ------------------------------------------------------------
    // serial frame receive
    // ------------------------------------------------------------
    // count saturates so an overlong frame never wraps back to 16
    always_ff @(posedge core_clk)
    begin
        if (!reset_n)
        begin
            bit_cnt_reg <= 5'h00;
            rx_shift_reg <= 16'h0000;
        end
        else if (cs_fall)
        begin
            bit_cnt_reg <= 5'h00;
        end
        else if (sck_fall)
        begin
            rx_shift_reg <= {rx_shift_reg[14:0], si};
            if (bit_cnt_reg != BIT_CNT_MAX)
                bit_cnt_reg <= bit_cnt_reg + 5'h01;
        end
    end

    assign instr_now = {rx_shift_reg[6:0], si};
    assign decode_strobe = sck_fall && (bit_cnt_reg == INSTR_LAST_BIT);
    assign wdata = rx_shift_reg[7:0];

    // instruction decode and answer byte
    always_comb
    begin
        cmd_ok = 1'b1;
        answer = WRITE_ANSWER;
        case (instr_now[5:0])
            RD_ID: answer = DEVICE_ID;
            RD_REV: answer = REVISION;
            RD_DIA1: answer = dia1_view;
            RD_DIA2: answer = dia2_view;
            RD_CONFIG: answer = config_view;
            RD_STATCON: answer = statcon_view;
            RD_SPECIAL: answer = special_reg;
            WR_DIA1, WR_DIA2, WR_CONFIG, WR_STATCON, WR_SPECIAL: answer = WRITE_ANSWER;
            default: cmd_ok = 1'b0;
        endcase
        if (instr_now[7:6] != CHIP_ADDR)
            cmd_ok = 1'b0;
        if (!cmd_ok)
            answer = INVALID_ANSWER;
    end

    // latch the instruction after its eighth bit
    always_ff @(posedge core_clk)
    begin
        if (!reset_n)
        begin
            instr_reg <= 8'h00;
            instr_ok_reg <= 1'b0;
        end
        else if (cs_fall)
        begin
            instr_ok_reg <= 1'b0;
        end
        else if (decode_strobe)
        begin
            instr_reg <= instr_now;
            instr_ok_reg <= cmd_ok;
        end
    end

    // writes only land on a complete, valid 16-clock frame
    assign commit = cs_rise && (bit_cnt_reg == FRAME_BITS) && instr_ok_reg && instr_reg[RW_BIT];
    assign read_dia2 = decode_strobe && cmd_ok && (instr_now[5:0] == RD_DIA2);

    // failure flag reported in the next frame's check byte
    always_ff @(posedge core_clk)
    begin
        if (!reset_n)
            trans_fail_reg <= 1'b0;
        else if (cs_rise && ((bit_cnt_reg != FRAME_BITS) || !instr_ok_reg))
            trans_fail_reg <= 1'b1;
        else if (cs_fall)
            trans_fail_reg <= 1'b0;
    end

    // ------------------------------------------------------------
    // serial frame transmit
    // ------------------------------------------------------------
    // first bit shows at select, the rest move on rising clock edges
    always_ff @(posedge core_clk)
    begin
        if (!reset_n)
        begin
            tx_shift_reg <= 8'h00;
            so_out <= 1'b0;
            so_oe <= 1'b0;
        end
        else if (cs_fall)
        begin
            // first rise shifts nothing and the second releases bit 7, so the byte sits one place lower
            tx_shift_reg <= {1'b0, CHECK_FIXED, trans_fail_reg, 1'b0};
            so_out <= 1'b0;
            so_oe <= 1'b0;
        end
        else if (cs_rise)
        begin
            so_oe <= 1'b0;
        end
        else if (decode_strobe)
        begin
            tx_shift_reg <= answer;
        end
        else if (sck_rise && (bit_cnt_reg != 5'h00))
        begin
            so_out <= tx_shift_reg[7];
            tx_shift_reg <= {tx_shift_reg[6:0], 1'b0};
            // two leading check bits stay released to avoid bus fights
            so_oe <= (bit_cnt_reg >= SO_ENABLE_FROM);
        end
    end

    // ------------------------------------------------------------
    // register write decode
    // ------------------------------------------------------------
    assign transfer = commit && (instr_reg[5:0] == WR_STATCON) && !wdata[TRANSFER_BIT]
                      && !mon.vs_undervoltage;
    assign diag2_clear = commit && (instr_reg[5:0] == WR_STATCON) && !wdata[DIAG2_CLEAR_BIT];
    assign serial_command_reset = commit && (instr_reg[5:0] == WR_CONFIG) && !wdata[CONFIG_RESET_BIT];

    // ------------------------------------------------------------
    // first diagnosis register
    // ------------------------------------------------------------
    // a new fault lands in the same cycle as a clear and wins
    always_ff @(posedge core_clk)
    begin
        if (!reset_n)
        begin
            ot1_reg <= 1'b1;
            diag1_code_reg <= NO_FAILURE;
        end
        else
        begin
            if (serial_command_reset || enable_edge_reset || transfer)
            begin
                ot1_reg <= 1'b1;
                diag1_code_reg <= NO_FAILURE;
            end
            if (mon.overtemp)
                ot1_reg <= 1'b0;
            // only the first latched fault is kept; reads leave it alone
            if (fault_valid && ((diag1_code_reg == NO_FAILURE) || transfer || enable_edge_reset
                                || serial_command_reset))
                diag1_code_reg <= fault_code;
        end
    end

    // supply under-voltage code shows live, never stored
    assign dia1_view = {~stage_disabled, ot1_reg, 2'b00,
                        mon.vs_undervoltage ? VS_UNDERVOLTAGE_CODE : diag1_code_reg};

    // ------------------------------------------------------------
    // second diagnosis register
    // ------------------------------------------------------------
    // a transfer in the same write as a clear is kept
    always_ff @(posedge core_clk)
    begin
        if (!reset_n)
        begin
            ot2_reg <= 1'b1;
            diag2_code_reg <= NO_FAILURE;
        end
        else
        begin
            if (serial_command_reset || diag2_clear)
            begin
                ot2_reg <= 1'b1;
                diag2_code_reg <= NO_FAILURE;
            end
            if (transfer)
            begin
                ot2_reg <= ot1_reg;
                diag2_code_reg <= diag1_code_reg;
            end
        end
    end

    // clear-on-read info bits, low while active; a new event beats the read
    always_ff @(posedge core_clk)
    begin
        if (!reset_n)
        begin
            cur_red_reg <= 1'b1;
            cur_lim_reg <= 1'b1;
        end
        else
        begin
            if (read_dia2 || enable_edge_reset || diag2_clear || serial_command_reset)
            begin
                cur_red_reg <= 1'b1;
                cur_lim_reg <= 1'b1;
            end
            if (mon.current_reduction)
                cur_red_reg <= 1'b0;
            if (mon.current_limit)
                cur_lim_reg <= 1'b0;
        end
    end

    assign dia2_view = {cur_red_reg, cur_lim_reg, ot2_reg, 1'b0, diag2_code_reg};

    // ------------------------------------------------------------
    // supply monitor status and control
    // ------------------------------------------------------------
    // only the three configuration bits are stored
    always_ff @(posedge core_clk)
    begin
        if (!reset_n || serial_command_reset)
            statcon_cfg_reg <= STATCON_CFG_POR;
        else if (commit && (instr_reg[5:0] == WR_STATCON))
            statcon_cfg_reg <= wdata[7:5];
    end

    // latch off makes the flag follow the comparator
    always_ff @(posedge core_clk)
    begin
        if (!reset_n)
            ov_flag_reg <= 1'b0;
        else if (mon.vdd_overvoltage)
            ov_flag_reg <= 1'b1;
        else if (!statcon_cfg_reg[LATCH_EN_BIT - 5] || serial_command_reset)
            ov_flag_reg <= 1'b0;
    end

    // clear bits always read 1, status bits are live or latched
    assign statcon_view = {statcon_cfg_reg, 1'b1, 1'b1, ability, ~mon.vdd_undervoltage, ~ov_flag_reg};

    // ------------------------------------------------------------
    // edge rate and clock options
    // ------------------------------------------------------------
    always_ff @(posedge core_clk)
    begin
        if (!reset_n || serial_command_reset)
            special_reg <= SPECIAL_POR;
        else if (commit && (instr_reg[5:0] == WR_SPECIAL))
            special_reg <= wdata;
    end

    // read-only configuration; stage-control bits forced while disabled
    assign config_view = {CONFIG_POR[7], CONFIG_POR[6:4] | {3{stage_disabled}}, CONFIG_POR[3:0]};

    // ------------------------------------------------------------
    // outputs
    // ------------------------------------------------------------
    always_ff @(posedge core_clk)
    begin
        if (!reset_n)
        begin
            options <= '{slew_select: SPECIAL_POR[SLEW_BIT], clock_jitter_enable: SPECIAL_POR[JITTER_BIT],
                         open_load_filter: SPECIAL_POR[OL_FILTER_BIT], vdd_test_off: STATCON_CFG_POR[2],
                         vdd_test_lift: STATCON_CFG_POR[1]};
        end
        else
        begin
            options.slew_select <= special_reg[SLEW_BIT];
            options.clock_jitter_enable <= special_reg[JITTER_BIT];
            options.open_load_filter <= special_reg[OL_FILTER_BIT];
            options.vdd_test_off <= statcon_cfg_reg[2];
            options.vdd_test_lift <= statcon_cfg_reg[1];
        end
    end

    // ability pin pulled low on any logic supply fault
    always_ff @(posedge core_clk)
    begin
        if (!reset_n)
        begin
            ability_pin_out <= 1'b0;
            ability_pin_oe <= 1'b0;
        end
        else
        begin
            ability_pin_out <= 1'b0;
            ability_pin_oe <= mon.vdd_undervoltage | mon.vdd_overvoltage;
        end
    end

endmodule : bridge_driver_status_special_regs

// File: verilog/bridge_regs_pkg.sv
package bridge_regs_pkg;

    // ------------------------------------------------------------
    // serial frame
    // ------------------------------------------------------------
    localparam logic [4:0] FRAME_BITS = 5'h10;
    localparam logic [4:0] INSTR_LAST_BIT = 5'h07;
    localparam logic [4:0] BIT_CNT_MAX = 5'h1F;
    localparam logic [4:0] SO_ENABLE_FROM = 5'h02;
    localparam logic [1:0] CHIP_ADDR = 2'h0;
    localparam logic [4:0] CHECK_FIXED = 5'h15;
    localparam logic [7:0] WRITE_ANSWER = 8'h00;
    localparam logic [7:0] INVALID_ANSWER = 8'hFF;
    localparam int RW_BIT = 5;

    // instruction codes, read/write flag included
    localparam logic [5:0] RD_ID = 6'h04;
    localparam logic [5:0] RD_REV = 6'h06;
    localparam logic [5:0] RD_DIA1 = 6'h10;
    localparam logic [5:0] RD_DIA2 = 6'h18;
    localparam logic [5:0] RD_CONFIG = 6'h08;
    localparam logic [5:0] RD_STATCON = 6'h0C;
    localparam logic [5:0] RD_SPECIAL = 6'h0E;
    localparam logic [5:0] WR_DIA1 = 6'h30;
    localparam logic [5:0] WR_DIA2 = 6'h38;
    localparam logic [5:0] WR_CONFIG = 6'h28;
    localparam logic [5:0] WR_STATCON = 6'h2C;
    localparam logic [5:0] WR_SPECIAL = 6'h2E;

    // identity values, arbitrary
    localparam logic [7:0] DEVICE_ID = 8'h5A;
    localparam logic [7:0] REVISION = 8'h01;

    // ------------------------------------------------------------
    // field positions and reset values
    // ------------------------------------------------------------
    localparam int LATCH_EN_BIT = 5;
    localparam int DIAG2_CLEAR_BIT = 4;
    localparam int TRANSFER_BIT = 3;
    localparam int CONFIG_RESET_BIT = 1;
    localparam int SLEW_BIT = 2;
    localparam int JITTER_BIT = 0;
    localparam int OL_FILTER_BIT = 4;
    localparam logic [2:0] STATCON_CFG_POR = 3'h6;
    localparam logic [7:0] SPECIAL_POR = 8'h59;
    localparam logic [7:0] CONFIG_POR = 8'hFA;
    localparam logic [3:0] NO_FAILURE = 4'hF;
    localparam logic [3:0] VS_UNDERVOLTAGE_CODE = 4'hD;
    // pin order {chip_select_n, sck, si, disable, ability}
    localparam logic [4:0] PIN_IDLE = 5'h11;

    // ------------------------------------------------------------
    // carriers
    // ------------------------------------------------------------
    typedef struct packed {
        logic vs_undervoltage;
        logic vdd_undervoltage;
        logic vdd_overvoltage;
        logic overtemp;
        logic current_limit;
        logic current_reduction;
    } monitor_t;

    localparam monitor_t MONITOR_IDLE = '{default: 1'b0};

    typedef struct packed {
        logic slew_select;
        logic clock_jitter_enable;
        logic open_load_filter;
        logic vdd_test_off;
        logic vdd_test_lift;
    } option_out_t;

endpackage : bridge_regs_pkg

// File: verif/bridge_regs_sva.sv
`timescale 1ns/1ps

module bridge_regs_sva
    import bridge_regs_pkg::*;
(
    // clock and reset
    input wire logic core_clk,
    input wire logic reset_n,
    // serial and enable pins
    input wire logic chip_select_n_pin,
    input wire logic so_oe,
    input wire logic disable_pin,
    input wire logic ability_pin_out,
    input wire logic ability_pin_oe,
    // monitors and options
    input wire bridge_regs_pkg::monitor_t monitor_in,
    input wire bridge_regs_pkg::option_out_t options
);
    // ----
    // helper: cycles since select was last low
    // ----
    logic [3:0] idle_cnt;

    // saturates so a long idle spell never wraps back into the commit window
    always_ff @(posedge core_clk)
    begin
        if (!reset_n || !chip_select_n_pin)
            idle_cnt <= 4'h0;
        else if (idle_cnt != 4'hF)
            idle_cnt <= idle_cnt + 4'h1;
    end

    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!reset_n);

    // ----
    // assertions
    // ----
    chk_por_options: assert property ($rose(reset_n) |-> options == 5'h0F && !so_oe)
        else $error("options not at power-up values");
    chk_slew_commit: assert property ($changed(options.slew_select) |-> idle_cnt < 4'hC)
        else $error("slew select changed outside a frame commit");
    chk_jitter_commit: assert property ($changed(options.clock_jitter_enable) |-> idle_cnt < 4'hC)
        else $error("jitter enable changed outside a frame commit");
    chk_cfg_commit: assert property ($changed({options.vdd_test_off, options.vdd_test_lift}) |-> idle_cnt < 4'hC)
        else $error("test threshold bits changed outside a frame commit");
    chk_disable_keeps: assert property ($rose(disable_pin) && idle_cnt == 4'hF |=> $stable(options) [*4])
        else $error("disable edge disturbed the option bits");
    chk_open_drain: assert property (ability_pin_oe |-> ability_pin_out == 1'b0)
        else $error("ability pin driven high");
    chk_ov_pulls: assert property (monitor_in.vdd_overvoltage [*5] |-> ability_pin_oe)
        else $error("over-voltage did not pull the ability pin");
    chk_ability_free: assert property ((!monitor_in.vdd_overvoltage && !monitor_in.vdd_undervoltage) [*6]
        |-> !ability_pin_oe)
        else $error("ability pin pulled without a supply fault");
    chk_so_quiet: assert property (chip_select_n_pin [*5] |-> !so_oe)
        else $error("data out driven while not selected");
    chk_so_late: assert property ($fell(chip_select_n_pin) |=> !so_oe [*3])
        else $error("data out driven during the tristate bits");

    // main scenarios reached
    cover property ($fell(options.clock_jitter_enable));
    cover property ($rose(ability_pin_oe));
    cover property ($rose(so_oe));
endmodule : bridge_regs_sva

bind bridge_driver_status_special_regs bridge_regs_sva chk (.core_clk, .reset_n, .chip_select_n_pin, .so_oe,
    .disable_pin, .ability_pin_out, .ability_pin_oe, .monitor_in, .options);

// File: verif/spi_host_model.sv
`timescale 1ns/1ps

module spi_host_model (
    // clock
    input wire logic core_clk,
    // serial lines
    output logic chip_select_n_pin,
    output logic sck_pin,
    output logic si_pin,
    input wire logic so_out,
    input wire logic so_oe
);
    // ----
    // frame engine
    // ----
    localparam int HALF = 5; // above the four-cycle minimum half period

    // idle: deselected, clock low
    initial
    begin
        chip_select_n_pin = 1'b1;
        sck_pin = 1'b0;
        si_pin = 1'b0;
    end

    // si moves on the rise so it is settled long before the sampling fall
    task automatic xfer(input logic [7:0] ins, input logic [7:0] dat, output logic [7:0] chk,
        output logic [7:0] ans);
        logic [15:0] tx;
        logic [15:0] rx;
        tx = {ins, dat};
        @(negedge core_clk);
        chip_select_n_pin = 1'b0;
        for (int i = 15; i >= 0; i--)
        begin
            repeat (HALF) @(negedge core_clk);
            sck_pin = 1'b1;
            si_pin = tx[i];
            repeat (HALF) @(negedge core_clk);
            rx[i] = so_oe ? so_out : ~so_out; // released line never passes for data
            sck_pin = 1'b0;
        end
        repeat (HALF) @(negedge core_clk);
        chip_select_n_pin = 1'b1;
        si_pin = ~si_pin; // idle line does not keep the last bit
        repeat (8) @(negedge core_clk);
        chk = rx[15:8];
        ans = rx[7:0];
    endtask : xfer
endmodule : spi_host_model

// File: verif/testbench.sv
`timescale 1ns/1ps

module testbench;
    import bridge_regs_pkg::*;
    // ----
    // pins and model state
    // ----
    logic core_clk;
    logic reset_n;
    logic chip_select_n_pin;
    logic sck_pin;
    logic si_pin;
    logic so_out;
    logic so_oe;
    logic disable_pin;
    logic ability_pin_in;
    logic ability_pin_out;
    logic ability_pin_oe;
    logic abe_ext;
    monitor_t monitor_in;
    logic fault_valid;
    logic [3:0] fault_code;
    option_out_t options;
    int fails;
    int checks;
    int cycles;
    int seed = 67864;
    logic [7:0] m_spec;
    logic [2:0] m_cfg;
    logic m_ov;
    logic [7:0] chk;
    logic [7:0] ans;
    logic [7:0] d;
    logic [7:0] bad_q[$] = '{8'h3F, 8'h4E};

    bridge_driver_status_special_regs uut (.core_clk, .reset_n, .chip_select_n_pin, .sck_pin, .si_pin, .so_out,
        .so_oe, .disable_pin, .ability_pin_in, .ability_pin_out, .ability_pin_oe, .monitor_in, .fault_valid,
        .fault_code, .options);
    spi_host_model host (.core_clk, .chip_select_n_pin, .sck_pin, .si_pin, .so_out, .so_oe);

    // open-drain ability line, pulled up outside
    assign ability_pin_in = ability_pin_oe ? ability_pin_out : abe_ext;

    // 200 MHz clock
    initial
    begin
        core_clk = 1'b0;
        forever #2.5 core_clk = ~core_clk;
    end

    // ----
    // checking and reporting
    // ----
    task automatic conclude();
        if (fails == 0 && checks > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask : conclude

    task automatic cmp_reg(input logic [7:0] got, input logic [7:0] exp);
        checks++;
        if (got !== exp)
        begin
            fails++;
            $display("MISMATCH %0t got %0h expected %0h", $time, got, exp);
        end
    endtask : cmp_reg

    task automatic cmp_opt(input logic [4:0] got, input logic [4:0] exp);
        checks++;
        if (got !== exp)
        begin
            fails++;
            $display("MISMATCH %0t got %0h expected %0h", $time, got, exp);
        end
    endtask : cmp_opt

    // hang guard, well above the expected run length
    always @(posedge core_clk)
    begin
        cycles++;
        if (cycles == 20000)
        begin
            fails++;
            conclude();
        end
    end

    // ----
    // bus helpers
    // ----
    task automatic rd(input logic [5:0] cmd, input logic [7:0] exp);
        host.xfer({2'h0, cmd}, 8'h00, chk, ans);
        cmp_reg(ans, exp);
    endtask : rd

    task automatic wr(input logic [5:0] cmd, input logic [7:0] dat);
        host.xfer({2'h0, cmd}, dat, chk, ans);
        cmp_reg(ans, WRITE_ANSWER);
    endtask : wr

    task automatic nap(input int n);
        repeat (n) @(negedge core_clk);
    endtask : nap

    function automatic logic [7:0] stat_exp();
        return {m_cfg, 2'b11, abe_ext, 1'b1, ~m_ov};
    endfunction : stat_exp

    // ----
    // main sequence
    // ----
    initial
    begin
        reset_n = 1'b0;
        disable_pin = 1'b0;
        abe_ext = 1'b1;
        monitor_in = MONITOR_IDLE;
        fault_valid = 1'b0;
        fault_code = 4'h0;
        m_spec = SPECIAL_POR;
        m_cfg = STATCON_CFG_POR;
        m_ov = 1'b0;
        nap(16);
        reset_n = 1'b1;
        nap(8);
        cmp_opt(options, 5'h0F);
        rd(RD_SPECIAL, m_spec);
        rd(RD_STATCON, stat_exp());
        // random contents, read back and seen at the options
        for (int i = 0; i < 6; i++)
        begin
            d = 8'($random(seed));
            wr(WR_SPECIAL, d);
            m_spec = d;
            rd(RD_SPECIAL, m_spec);
            cmp_opt(options, {m_spec[2], m_spec[0], m_spec[4], m_cfg[2:1]});
            d = 8'($random(seed)) | 8'h18;
            wr(WR_STATCON, d);
            m_cfg = d[7:5];
            rd(RD_STATCON, stat_exp());
        end
        // latched over-voltage survives power-stage under-voltage
        m_cfg[0] = 1'b1;
        wr(WR_STATCON, {m_cfg, 5'h18});
        monitor_in.vdd_overvoltage = 1'b1;
        nap(10);
        monitor_in.vdd_overvoltage = 1'b0;
        nap(10);
        m_ov = 1'b1;
        rd(RD_STATCON, stat_exp());
        monitor_in.vs_undervoltage = 1'b1;
        nap(10);
        rd(RD_STATCON, stat_exp());
        // transfer refused while under-voltage
        fault_code = 4'h5;
        fault_valid = 1'b1;
        nap(1);
        fault_valid = 1'b0;
        wr(WR_STATCON, {m_cfg, 5'h10});
        monitor_in.vs_undervoltage = 1'b0;
        nap(10);
        rd(RD_DIA1, 8'hC5);
        rd(RD_DIA1, 8'hC5);
        rd(RD_DIA2, 8'hEF);
        m_cfg[0] = 1'b0;
        wr(WR_STATCON, {m_cfg, 5'h18});
        m_ov = 1'b0;
        rd(RD_STATCON, stat_exp());
        // transfer, then clear of the history
        wr(WR_STATCON, {m_cfg, 5'h10});
        rd(RD_DIA1, 8'hCF);
        rd(RD_DIA2, 8'hE5);
        wr(WR_STATCON, {m_cfg, 5'h08});
        rd(RD_DIA2, 8'hEF);
        // clear-on-read information bit
        monitor_in.current_limit = 1'b1;
        nap(6);
        monitor_in.current_limit = 1'b0;
        nap(6);
        rd(RD_DIA2, 8'hAF);
        rd(RD_DIA2, 8'hEF);
        // disable level and edges
        fault_code = 4'h2;
        fault_valid = 1'b1;
        nap(1);
        fault_valid = 1'b0;
        disable_pin = 1'b1;
        nap(6);
        rd(RD_DIA1, 8'h4F);
        rd(RD_CONFIG, CONFIG_POR);
        disable_pin = 1'b0;
        nap(6);
        rd(RD_DIA1, 8'hCF);
        // refused frames: no change, failure flagged once
        m_spec = 8'h22;
        wr(WR_SPECIAL, m_spec);
        foreach (bad_q[i])
        begin
            host.xfer(bad_q[i], 8'h00, chk, ans);
            cmp_reg(ans, INVALID_ANSWER);
            rd(RD_SPECIAL, m_spec);
            cmp_reg({7'h00, chk[0]}, 8'h01);
            rd(RD_SPECIAL, m_spec);
            cmp_reg({7'h00, chk[0]}, 8'h00);
        end
        // serial-command reset
        wr(WR_CONFIG, 8'hFD);
        m_spec = SPECIAL_POR;
        m_cfg = STATCON_CFG_POR;
        rd(RD_SPECIAL, m_spec);
        rd(RD_STATCON, stat_exp());
        cmp_opt(options, 5'h0F);
        // logic supply under-voltage in status, then latched over-temperature
        monitor_in.vdd_undervoltage = 1'b1;
        nap(6);
        rd(RD_STATCON, {m_cfg, 5'h19});
        monitor_in = MONITOR_IDLE;
        nap(10);
        monitor_in.overtemp = 1'b1;
        monitor_in.current_reduction = 1'b1;
        nap(6);
        monitor_in = MONITOR_IDLE;
        nap(6);
        rd(RD_DIA1, 8'h8F);
        rd(RD_DIA2, 8'h6F);
        wr(WR_STATCON, {m_cfg, 5'h10});
        rd(RD_DIA2, 8'hCF);
        rd(RD_DIA1, 8'hCF);
        conclude();
    end
endmodule : testbench
